// file: nce_exec.sv
// nibble cpu execute unit: ram swaps, pointer loads, tests, port i/o, timer, lookup
// assumes rom_data answers rom_addr combinationally within the same pclk cycle
//
// Function
// [RULE1] store immediate writes ram at pointer, then increments digit pointer
// [RULE2] plain swap exchanges acc with ram, xors row with r, never skips
// [RULE3] direct swap, prefix then 1 r d, exchanges acc with ram(r,d), pointer kept
// [RULE4] swap-decrement exchanges, decrements digit, xors row, skips past zero
// [RULE5] swap-increment exchanges, increments digit, xors row, skips past fifteen
// [RULE6] short pointer load encodes d minus one; long form is prefix then 1 r d
// [RULE7] after a pointer load, following pointer loads are skipped
// [RULE8] function-select load latches y into the function-select register
// [RULE9] acc/row swap zeroes acc bit 3, or bits 3 and 2 on small rom
// [RULE10] port-g tests skip when selected bit, or all four bits, are zero
// [RULE11] ram bit test skips when selected bit of pointed ram is zero
// [RULE12] skipped instructions still fetched; indirect jump and lookup then take one cycle
// [RULE13] timer-flag test skips and clears when the overflow latch is set
// [RULE14] loading timer with msb one sets the overflow flag
// [RULE15] idle stops execution until the time-base counter overflows
// [RULE16] fall latches set after high-to-low held two cycles, clear on reset
// [RULE17] reading fall latches gives latch3, osc pin, zero, latch0, then clears
// [RULE18] l-port read puts high nibble in ram, low in acc; g, in read to acc
// [RULE19] serial swap exchanges acc with shift register, carry to clock latch
// [RULE20] lookup pushes pc+1, reads rom into q latch, pops over two cycles
// [RULE21] indirect jump loads pc low byte from rom, keeps pc high bits
// [RULE22] page-relative indirect ops use the incremented pc page
// [RULE23] pointer is 3-bit row over 4-bit digit
// [RULE24] timer mode chooses time-base or event counting; idle needs time-base
// [RULE25] prefix byte fetches the next byte and decodes the pair together
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
module nce_exec (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata_ff,
  output logic             pready_ff,
  output logic             pslverr_ff,
  output logic [10:0]      rom_addr_ff,
  input  wire logic [7:0]  rom_data,
  input  wire logic [3:0]  g_in,
  input  wire logic [3:0]  in_port,
  input  wire logic [7:0]  l_in,
  input  wire logic        osc_out_pin,
  input  wire logic        carry_in,
  input  wire logic        tmr_event_in,
  output logic [3:0]       g_out_ff,
  output logic [3:0]       d_out_ff,
  output logic [7:0]       q_out_ff,
  output logic [3:0]       en_out_ff,
  output logic [3:0]       sio_out_ff,
  output logic             skl_out_ff,
  output logic             idle_out_ff
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  nce_pkg::nce_state_e state_ff, nxt_state;
  logic [10:0] pc_ff, nxt_pc, sa_ff, nxt_sa, sb_ff, nxt_sb, sc_ff, nxt_sc, nxt_rom_addr;
  logic [3:0]  a_ff, nxt_a, dig_ff, nxt_dig, nxt_g, nxt_d, nxt_en, nxt_sio;
  logic [2:0]  row_ff, nxt_row;
  logic [7:0]  first_ff, nxt_first, t_ff, nxt_t, nxt_q;
  logic        skip_ff, nxt_skip, chain_ff, nxt_chain, tovf_ff, nxt_skl;
  logic        evt_ff, ram_we, t_load, t_clr, fall_clr;
  logic [6:0]  ram_wa;
  logic [3:0]  ram_wd;
  logic [nce_pkg::NCE_CFG_W-1:0] cfg_ff;
  logic [3:0]  ram_mem [0:nce_pkg::NCE_RAM_WORDS-1];
  logic        fall3, fall0;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire [7:0]  op         = rom_data;
  wire [6:0]  b_addr     = {row_ff, dig_ff}; // [RULE23]
  wire [3:0]  m          = ram_mem[b_addr];
  wire [3:0]  m_dir      = ram_mem[op[6:0]];
  wire [10:0] pc_inc     = pc_ff + nce_pkg::NCE_ONE11;
  wire [2:0]  r_low      = {1'b0, op[5:4]};
  wire        low_grp    = op[7:6] == nce_pkg::NCE_GRP_LOW;
  wire        is_prefix  = (op == nce_pkg::NCE_OP_PREFIX) || (op == nce_pkg::NCE_OP_DIRECT); // [RULE25]
  wire        is_store   = op[7:4] == nce_pkg::NCE_NIB_STORE_IMM;
  wire        is_sptr    = low_grp && (op[3:0] >= nce_pkg::NCE_NIB_PTR_MIN); // [RULE6]
  wire        is_swap    = low_grp && (op[3:0] == nce_pkg::NCE_NIB_SWAP);
  wire        is_swapdec = low_grp && (op[3:0] == nce_pkg::NCE_NIB_SWAP_DEC);
  wire        is_swapinc = low_grp && (op[3:0] == nce_pkg::NCE_NIB_SWAP_INC);
  wire        is_btest   = nce_pkg::nce_is_bit_test(op);
  wire        bit_zero_m = ~m[nce_pkg::nce_bit_sel(op)];
  wire        bit_zero_g = ~g_in[nce_pkg::nce_bit_sel(op)];
  wire        ev_mode    = cfg_ff[nce_pkg::NCE_CFG_EVT];
  wire        rom_1k     = cfg_ff[nce_pkg::NCE_CFG_ROM1K];
  wire        osc_bit    = cfg_ff[nce_pkg::NCE_CFG_OSCIN] ? osc_out_pin : 1'b1;
  wire [10:0] ind_addr   = {pc_inc[10:8], a_ff, m}; // [RULE22]
  wire        t_tick     = ev_mode ? (evt_ff & ~tmr_event_in) : 1'b1; // [RULE24]
  wire        t_ovf      = t_tick && (t_ff == nce_pkg::NCE_T_MAX);
  wire [3:0]  acc_row    = rom_1k ? {2'b00, row_ff[1:0]} : {1'b0, row_ff};
  wire [2:0]  row_acc    = rom_1k ? {1'b0, a_ff[1:0]} : a_ff[2:0];

  // ---------------------------------------------------------------
  // execute
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_pc    = pc_ff;
    nxt_sa    = sa_ff;
    nxt_sb    = sb_ff;
    nxt_sc    = sc_ff;
    nxt_a     = a_ff;
    nxt_row   = row_ff;
    nxt_dig   = dig_ff;
    nxt_first = first_ff;
    nxt_skip  = skip_ff;
    nxt_chain = chain_ff;
    nxt_g     = g_out_ff;
    nxt_d     = d_out_ff;
    nxt_q     = q_out_ff;
    nxt_en    = en_out_ff;
    nxt_sio   = sio_out_ff;
    nxt_skl   = skl_out_ff;
    nxt_t     = t_ff;
    ram_we    = 1'b0;
    ram_wa    = b_addr;
    ram_wd    = a_ff;
    t_load    = 1'b0;
    t_clr     = 1'b0;
    fall_clr  = 1'b0;
    nxt_rom_addr = pc_ff;
    case (state_ff)
      nce_pkg::NCE_FETCH: begin
        nxt_pc = pc_inc;
        nxt_rom_addr = pc_inc;
        if (is_prefix) begin
          nxt_first = op;
          nxt_state = nce_pkg::NCE_SECOND;
        end else begin
          nxt_skip  = 1'b0;
          nxt_chain = 1'b0;
          if (skip_ff) begin
            nxt_skip = 1'b0; // [RULE12]
          end else if (chain_ff && is_sptr) begin
            nxt_chain = 1'b1; // [RULE7]
          end else if (is_store) begin
            ram_we  = 1'b1; // [RULE1]
            ram_wd  = op[3:0];
            nxt_dig = dig_ff + nce_pkg::NCE_ONE4;
          end else if (is_sptr) begin
            nxt_row   = r_low; // [RULE6]
            nxt_dig   = op[3:0] + nce_pkg::NCE_ONE4;
            nxt_chain = 1'b1;
          end else if (is_swap || is_swapdec || is_swapinc) begin
            ram_we  = 1'b1; // [RULE2]
            nxt_a   = m;
            nxt_row = row_ff ^ r_low;
            if (is_swapdec) begin
              nxt_dig  = dig_ff - nce_pkg::NCE_ONE4; // [RULE4]
              nxt_skip = dig_ff == nce_pkg::NCE_DIG_MIN;
            end else if (is_swapinc) begin
              nxt_dig  = dig_ff + nce_pkg::NCE_ONE4; // [RULE5]
              nxt_skip = dig_ff == nce_pkg::NCE_DIG_MAX;
            end
          end else if (is_btest) begin
            nxt_skip = bit_zero_m; // [RULE11]
          end else if (op == nce_pkg::NCE_OP_ACC_ROW) begin
            nxt_a   = acc_row; // [RULE9]
            nxt_row = row_acc;
          end else if (op == nce_pkg::NCE_OP_TFLAG) begin
            nxt_skip = tovf_ff; // [RULE13]
            t_clr    = tovf_ff;
          end else if (op == nce_pkg::NCE_OP_ACC_SER) begin
            nxt_a   = sio_out_ff; // [RULE19]
            nxt_sio = a_ff;
            nxt_skl = carry_in;
          end else if ((op == nce_pkg::NCE_OP_LOOKUP) || (op == nce_pkg::NCE_OP_JUMP_IND)) begin
            nxt_first    = op;
            nxt_state    = nce_pkg::NCE_INDIRECT;
            nxt_rom_addr = ind_addr; // [RULE22]
            if (op == nce_pkg::NCE_OP_LOOKUP) begin
              nxt_sa = pc_inc; // [RULE20]
              nxt_sb = sa_ff;
              nxt_sc = sb_ff;
            end
          end
        end
      end
      nce_pkg::NCE_SECOND: begin
        nxt_pc       = pc_inc;
        nxt_rom_addr = pc_inc;
        nxt_state    = nce_pkg::NCE_FETCH;
        nxt_skip     = 1'b0;
        nxt_chain    = 1'b0;
        if (skip_ff) begin
          nxt_skip = 1'b0; // [RULE12]
        end else if (first_ff == nce_pkg::NCE_OP_DIRECT) begin
          nxt_a = m_dir; // [RULE3]
          if (op[7]) begin
            ram_we = 1'b1;
            ram_wa = op[6:0];
          end
        end else if (op[7]) begin
          nxt_chain = 1'b1; // [RULE7]
          if (!chain_ff) begin
            nxt_row = op[6:4]; // [RULE6]
            nxt_dig = op[3:0];
          end
        end else if (op[7:4] == nce_pkg::NCE_NIB_FSEL) begin
          nxt_en = op[3:0]; // [RULE8]
        end else if (op[7:4] == nce_pkg::NCE_NIB_GOUT) begin
          nxt_g = op[3:0];
        end else if (op == nce_pkg::NCE_SB_GZERO) begin
          nxt_skip = g_in == nce_pkg::NCE_DIG_MIN; // [RULE10]
        end else if (nce_pkg::nce_is_bit_test(op)) begin
          nxt_skip = bit_zero_g; // [RULE10]
        end else if (op == nce_pkg::NCE_SB_RD_G) begin
          nxt_a = g_in; // [RULE18]
        end else if (op == nce_pkg::NCE_SB_RD_IN) begin
          nxt_a = in_port; // [RULE18]
        end else if (op == nce_pkg::NCE_SB_RD_FALL) begin
          nxt_a    = {fall3, osc_bit, 1'b0, fall0}; // [RULE17]
          fall_clr = 1'b1;
        end else if (op == nce_pkg::NCE_SB_RD_L) begin
          ram_we = 1'b1; // [RULE18]
          ram_wd = l_in[7:4];
          nxt_a  = l_in[3:0];
        end else if (op == nce_pkg::NCE_SB_LD_TMR) begin
          nxt_t  = {a_ff, m}; // [RULE14]
          t_load = 1'b1;
        end else if (op == nce_pkg::NCE_SB_RD_TMR) begin
          ram_we = 1'b1;
          ram_wd = t_ff[7:4];
          nxt_a  = t_ff[3:0];
        end else if (op == nce_pkg::NCE_SB_LD_Q) begin
          nxt_q = {a_ff, m};
        end else if (op == nce_pkg::NCE_SB_RD_Q) begin
          ram_we = 1'b1;
          ram_wd = q_out_ff[7:4];
          nxt_a  = q_out_ff[3:0];
        end else if (op == nce_pkg::NCE_SB_DIG_OUT) begin
          nxt_d = dig_ff;
        end else if (op == nce_pkg::NCE_SB_RAM_GOUT) begin
          nxt_g = m;
        end else if ((op == nce_pkg::NCE_SB_IDLE) && !ev_mode) begin
          nxt_state    = nce_pkg::NCE_IDLE; // [RULE15]
          nxt_rom_addr = pc_inc;
        end
      end
      nce_pkg::NCE_INDIRECT: begin
        nxt_state = nce_pkg::NCE_FETCH;
        if (first_ff == nce_pkg::NCE_OP_LOOKUP) begin
          nxt_q  = rom_data; // [RULE20]
          nxt_pc = sa_ff;
          nxt_sa = sb_ff;
          nxt_sb = sc_ff;
        end else begin
          nxt_pc = {pc_ff[10:8], rom_data}; // [RULE21]
        end
        nxt_rom_addr = nxt_pc;
      end
      nce_pkg::NCE_IDLE: begin
        if (t_ovf) begin
          nxt_state = nce_pkg::NCE_FETCH; // [RULE15]
        end
      end
      default: begin
        nxt_state = nce_pkg::NCE_FETCH;
      end
    endcase
    if (!t_load && t_tick) begin
      nxt_t = t_ff + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // sequencer and datapath registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff    <= nce_pkg::NCE_FETCH;
      pc_ff       <= '0;
      rom_addr_ff <= '0;
      sa_ff       <= '0;
      sb_ff       <= '0;
      sc_ff       <= '0;
      a_ff        <= '0;
      row_ff      <= '0;
      dig_ff      <= '0;
      first_ff    <= '0;
      skip_ff     <= 1'b0;
      chain_ff    <= 1'b0;
      idle_out_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      pc_ff       <= nxt_pc;
      rom_addr_ff <= nxt_rom_addr;
      sa_ff       <= nxt_sa;
      sb_ff       <= nxt_sb;
      sc_ff       <= nxt_sc;
      a_ff        <= nxt_a;
      row_ff      <= nxt_row;
      dig_ff      <= nxt_dig;
      first_ff    <= nxt_first;
      skip_ff     <= nxt_skip;
      chain_ff    <= nxt_chain;
      idle_out_ff <= nxt_state == nce_pkg::NCE_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // ports, timer and serial registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      g_out_ff   <= '0;
      d_out_ff   <= '0;
      q_out_ff   <= '0;
      en_out_ff  <= '0;
      sio_out_ff <= '0;
      skl_out_ff <= 1'b0;
      t_ff       <= '0;
      tovf_ff    <= 1'b0;
      evt_ff     <= 1'b0;
    end else begin
      g_out_ff   <= nxt_g;
      d_out_ff   <= nxt_d;
      q_out_ff   <= nxt_q;
      en_out_ff  <= nxt_en;
      sio_out_ff <= nxt_sio;
      skl_out_ff <= nxt_skl;
      t_ff       <= nxt_t;
      evt_ff     <= tmr_event_in;
      tovf_ff    <= t_ovf | (t_load & a_ff[3]) | (tovf_ff & ~t_clr); // [RULE14]
    end
  end

  // ---------------------------------------------------------------
  // data memory
  // ---------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (ram_we) begin
      ram_mem[ram_wa] <= ram_wd;
    end
  end

  // ---------------------------------------------------------------
  // falling-edge input latches
  // ---------------------------------------------------------------
  nce_fall_latch u_fall3 (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   (in_port[3]),
    .clr      (fall_clr),
    .latch_ff (fall3)
  );

  nce_fall_latch u_fall0 (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   (in_port[0]),
    .clr      (fall_clr),
    .latch_ff (fall0)
  );

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  wire        apb_setup = psel & ~penable;
  wire        apb_write = psel & penable & pready_ff & pwrite;
  wire        sel_cfg   = paddr == nce_pkg::NCE_CFG_OFF;
  wire        sel_stat  = paddr == nce_pkg::NCE_STAT_OFF;
  wire        sel_tmr   = paddr == nce_pkg::NCE_TMR_OFF;
  wire [31:0] rd_word   = sel_cfg  ? 32'(cfg_ff) :
                          sel_stat ? 32'({a_ff, row_ff, dig_ff, pc_ff}) :
                          sel_tmr  ? 32'({tovf_ff, t_ff}) : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= '0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      cfg_ff     <= '0;
    end else begin
      pready_ff  <= apb_setup;
      pslverr_ff <= apb_setup & ~(sel_cfg | sel_stat | sel_tmr);
      prdata_ff  <= apb_setup ? rd_word : '0;
      if (apb_write && sel_cfg) begin
        cfg_ff <= pwdata[nce_pkg::NCE_CFG_W-1:0]; // [RULE24]
      end
    end
  end

endmodule : nce_exec

// file: nce_pkg.sv
// nibble cpu execute unit: shared opcodes, field positions, register map and states
// assumes one instruction cycle per pclk edge and a 12-bit apb byte address
package nce_pkg;

  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    NCE_FETCH,
    NCE_SECOND,
    NCE_INDIRECT,
    NCE_IDLE
  } nce_state_e;

  // ---------------------------------------------------------------
  // single-byte opcodes and opcode nibbles
  // ---------------------------------------------------------------
  localparam logic [7:0] NCE_OP_PREFIX     = 8'h33;
  localparam logic [7:0] NCE_OP_DIRECT     = 8'h23;
  localparam logic [7:0] NCE_OP_ACC_ROW    = 8'h12;
  localparam logic [7:0] NCE_OP_TFLAG      = 8'h41;
  localparam logic [7:0] NCE_OP_ACC_SER    = 8'h4f;
  localparam logic [7:0] NCE_OP_LOOKUP     = 8'hbf;
  localparam logic [7:0] NCE_OP_JUMP_IND   = 8'hff;
  localparam logic [3:0] NCE_NIB_STORE_IMM = 4'h7;
  localparam logic [3:0] NCE_NIB_SWAP      = 4'h6;
  localparam logic [3:0] NCE_NIB_SWAP_DEC  = 4'h7;
  localparam logic [3:0] NCE_NIB_SWAP_INC  = 4'h4;
  localparam logic [3:0] NCE_NIB_PTR_MIN   = 4'h8;
  localparam logic [1:0] NCE_GRP_LOW       = 2'h0;

  // ---------------------------------------------------------------
  // second bytes after the prefix
  // ---------------------------------------------------------------
  localparam logic [3:0] NCE_NIB_FSEL      = 4'h6;
  localparam logic [3:0] NCE_NIB_GOUT      = 4'h5;
  localparam logic [7:0] NCE_SB_GZERO      = 8'h21;
  localparam logic [7:0] NCE_SB_RD_G       = 8'h2a;
  localparam logic [7:0] NCE_SB_RD_IN      = 8'h28;
  localparam logic [7:0] NCE_SB_RD_FALL    = 8'h29;
  localparam logic [7:0] NCE_SB_RD_L       = 8'h2e;
  localparam logic [7:0] NCE_SB_LD_TMR     = 8'h3f;
  localparam logic [7:0] NCE_SB_RD_TMR     = 8'h2f;
  localparam logic [7:0] NCE_SB_LD_Q       = 8'h3c;
  localparam logic [7:0] NCE_SB_RD_Q       = 8'h2c;
  localparam logic [7:0] NCE_SB_DIG_OUT    = 8'h3e;
  localparam logic [7:0] NCE_SB_RAM_GOUT   = 8'h3a;
  localparam logic [7:0] NCE_SB_IDLE       = 8'h38;

  // ---------------------------------------------------------------
  // datapath limits
  // ---------------------------------------------------------------
  localparam int         NCE_RAM_WORDS     = 128;
  localparam logic [3:0] NCE_DIG_MAX       = 4'hf;
  localparam logic [3:0] NCE_DIG_MIN       = 4'h0;
  localparam logic [3:0] NCE_ONE4          = 4'h1;
  localparam logic [10:0] NCE_ONE11        = 11'h001;
  localparam logic [7:0] NCE_T_MAX         = 8'hff;

  // ---------------------------------------------------------------
  // apb register map
  // ---------------------------------------------------------------
  localparam logic [11:0] NCE_CFG_OFF      = 12'h000;
  localparam logic [11:0] NCE_STAT_OFF     = 12'h004;
  localparam logic [11:0] NCE_TMR_OFF      = 12'h008;
  localparam int          NCE_CFG_W        = 3;
  localparam int          NCE_CFG_EVT      = 0;
  localparam int          NCE_CFG_ROM1K    = 1;
  localparam int          NCE_CFG_OSCIN    = 2;

  // selects the tested bit from the test opcode pattern
  function automatic logic [1:0] nce_bit_sel(input logic [7:0] op);
    return {op[1], op[4]};
  endfunction : nce_bit_sel

  // matches the bit test pattern 000x_00x1
  function automatic logic nce_is_bit_test(input logic [7:0] op);
    return (op[7:5] == 3'h0) && (op[3:2] == 2'h0) && op[0];
  endfunction : nce_is_bit_test

endpackage : nce_pkg

// file: nce_fall_latch.sv
// falling-edge input latch with a two-cycle low filter
// assumes pin_in is synchronous to pclk
`timescale 1ns/1ps
module nce_fall_latch (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_in,
  input  wire logic clr,
  output logic      latch_ff
);

  logic [1:0] hist_ff;
  wire        fall_seen = hist_ff[1] & ~hist_ff[0] & ~pin_in;

  // ---------------------------------------------------------------
  // history and sticky latch
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_ff  <= '0;
      latch_ff <= 1'b0;
    end else begin
      hist_ff  <= {hist_ff[0], pin_in};
      latch_ff <= fall_seen | (latch_ff & ~clr); // [RULE16]
    end
  end

endmodule : nce_fall_latch

// file: nce_exec_asserts.sv
// checker for the execute unit: apb handshake, rom address flow, output causes
// assumes one pclk domain, presetn asynchronous and active low
`timescale 1ns/1ps
module nce_exec_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready_ff,
  input wire logic        pslverr_ff,
  input wire logic [10:0] rom_addr_ff,
  input wire logic [7:0]  rom_data,
  input wire logic [3:0]  g_out_ff,
  input wire logic [3:0]  d_out_ff,
  input wire logic [7:0]  q_out_ff,
  input wire logic [3:0]  en_out_ff,
  input wire logic        idle_out_ff
);
  logic [1:0] run_ff;
  logic [1:0] nxt_run;
  logic       mapped;

  assign nxt_run = run_ff + {1'b0, ~&run_ff};
  assign mapped  = paddr inside {nce_pkg::NCE_CFG_OFF, nce_pkg::NCE_STAT_OFF, nce_pkg::NCE_TMR_OFF};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run_ff <= 2'h0;
    else run_ff <= nxt_run;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pready_setup: assert property (psel && !penable |=> pready_ff)
    else $error("no ready after setup");
  a_pready_cause: assert property (pready_ff |-> $past(psel && !penable) && psel && penable)
    else $error("ready without setup");
  a_err_map: assert property (pready_ff |-> pslverr_ff == !mapped)
    else $error("error flag wrong for address");
  a_rom_seq: assert property (
    run_ff == 2'h3 && !idle_out_ff && !$past(idle_out_ff) && !$past(idle_out_ff, 2)
    && !($past(rom_data) inside {8'hbf, 8'hff, 8'h38}) && !($past(rom_data, 2) inside {8'hbf, 8'hff})
    |-> rom_addr_ff == $past(rom_addr_ff) + 11'h001)
    else $error("rom address not sequential");
  a_en_cause: assert property ($changed(en_out_ff) |->
    $past(rom_data, 2) == 8'h33 && $past(rom_data[7:4]) == 4'h6)
    else $error("enable changed without load");
  a_dout_cause: assert property ($changed(d_out_ff) |->
    $past(rom_data, 2) == 8'h33 && $past(rom_data) == 8'h3e)
    else $error("d output changed without cause");
  a_gout_cause: assert property ($changed(g_out_ff) |->
    $past(rom_data, 2) == 8'h33 && ($past(rom_data[7:4]) == 4'h5 || $past(rom_data) == 8'h3a))
    else $error("g output changed without cause");
  a_q_cause: assert property ($changed(q_out_ff) |->
    ($past(rom_data, 2) == 8'h33 && $past(rom_data) == 8'h3c) || $past(rom_data, 2) == 8'hbf)
    else $error("q latch changed without cause");
endmodule : nce_exec_asserts

bind nce_exec nce_exec_asserts u_asserts (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .rom_addr_ff(rom_addr_ff),
  .rom_data(rom_data), .g_out_ff(g_out_ff), .d_out_ff(d_out_ff), .q_out_ff(q_out_ff),
  .en_out_ff(en_out_ff), .idle_out_ff(idle_out_ff));

// file: nce_rom_model.sv
// program rom model holding the test program, no-op filler elsewhere
// assumes the address is the execute unit's registered rom address
`timescale 1ns/1ps
module nce_rom_model (
  input  wire logic [10:0] rom_addr,
  output logic [7:0]       rom_data
);
  localparam logic [0:50][7:0] PROG = {
    8'h0f, 8'h3f, 8'h75, 8'h7f, 8'h0f, 8'h23, 8'h81, 8'h06,
    8'h07, 8'h75, 8'h33, 8'h3e, 8'h12, 8'h7c, 8'h33, 8'hff,
    8'h04, 8'h7f, 8'h4f, 8'h33, 8'h2e, 8'h03, 8'h7e, 8'h33,
    8'h3a, 8'h33, 8'h3c, 8'h33, 8'h66, 8'h33, 8'h29, 8'h4f,
    8'h33, 8'h29, 8'h33, 8'h21, 8'h4f, 8'h33, 8'h13, 8'h4f,
    8'h33, 8'h3f, 8'h41, 8'h33, 8'h38, 8'h41, 8'h33, 8'h3e,
    8'hbf, 8'hff, 8'h4f
  };

  // table reads beyond the program land on the no-op filler
  assign rom_data = (rom_addr < 11'h033) ? PROG[rom_addr[5:0]] : 8'h44;
endmodule : nce_rom_model

// file: tb_nibble_cpu_instruction_exec.sv
// bench: runs the rom program through the execute unit, then probes the apb registers
// assumes the rom model answers combinationally and pclk runs at 100 MHz
`timescale 1ns/1ps
module tb_nibble_cpu_instruction_exec;
  logic        pclk, presetn, psel, penable, pwrite, pready_ff, pslverr_ff, e;
  logic        osc_out_pin, carry_in, tmr_event_in, skl_out_ff, idle_out_ff;
  logic [3:0]  g_in, in_port, g_out_ff, d_out_ff, en_out_ff, sio_out_ff;
  logic [7:0]  l_in, rom_data, q_out_ff;
  logic [10:0] rom_addr_ff;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_ff, r;
  int          err_count, n_checks, idle_wait;

  nce_exec      dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .rom_addr_ff(rom_addr_ff), .rom_data(rom_data), .g_in(g_in), .in_port(in_port), .l_in(l_in),
    .osc_out_pin(osc_out_pin), .carry_in(carry_in), .tmr_event_in(tmr_event_in), .g_out_ff(g_out_ff),
    .d_out_ff(d_out_ff), .q_out_ff(q_out_ff), .en_out_ff(en_out_ff), .sio_out_ff(sio_out_ff),
    .skl_out_ff(skl_out_ff), .idle_out_ff(idle_out_ff));
  nce_rom_model u_rom (.rom_addr(rom_addr_ff), .rom_data(rom_data));

  task automatic end_of_test;
    if (err_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    psel    <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready_ff !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_count++;
        $display("mismatch %0t apb timeout", $time);
        end_of_test();
      end
      @(posedge pclk);
    end
    r = prdata_ff;
    e = pslverr_ff;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    presetn      = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 12'h000;
    pwdata       = 32'h0;
    g_in         = 4'h0;
    in_port      = 4'h9;
    l_in         = 8'h3b;
    osc_out_pin  = 1'b0;
    carry_in     = 1'b1;
    tmr_event_in = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    in_port <= 4'h0;
    repeat (50) @(posedge pclk);
    chk(d_out_ff, 4'hf);
    chk(g_out_ff, 4'h3);
    chk(q_out_ff, 8'hb3);
    chk(en_out_ff, 4'h6);
    chk(sio_out_ff, 4'hd);
    chk(skl_out_ff, 1'b1);
    chk(idle_out_ff, 1'b1);
    idle_wait = 0;
    while (idle_out_ff !== 1'b0) begin
      idle_wait++;
      if (idle_wait > 400) begin
        err_count++;
        $display("mismatch %0t idle timeout", $time);
        end_of_test();
      end
      @(posedge pclk);
    end
    repeat (12) @(posedge pclk);
    chk(q_out_ff, 8'h44);
    chk(d_out_ff, 4'hf);
    chk(sio_out_ff, 4'hd);
    apb(nce_pkg::NCE_STAT_OFF, 1'b0, 32'h0);
    chk(r[21:11], {4'h4, 3'h7, 4'h0});
    apb(nce_pkg::NCE_CFG_OFF, 1'b0, 32'h0);
    chk(r, 32'h0);
    apb(nce_pkg::NCE_CFG_OFF, 1'b1, 32'hffff_ffff);
    apb(nce_pkg::NCE_CFG_OFF, 1'b0, 32'h0);
    chk(r, 32'h7);
    apb(nce_pkg::NCE_TMR_OFF, 1'b0, 32'h0);
    chk(r[31:8], 24'h0);
    apb(12'h00c, 1'b1, 32'h5);
    chk(e, 1'b1);
    apb(12'h00c, 1'b0, 32'h0);
    chk({e, r}, {1'b1, 32'h0});
    end_of_test();
  end
endmodule : tb_nibble_cpu_instruction_exec
